// ---- design/music_msg_pkg.sv ----
// Constants for the music message builder
package music_msg_pkg;
  // Message kinds
  typedef enum logic [2:0] {
    KIND_NOTE_ON = 3'h0,
    KIND_NOTE_OFF = 3'h1,
    KIND_CONTROL = 3'h2,
    KIND_PAIRED_CONTROL = 3'h3,
    KIND_PROGRAM = 3'h4,
    KIND_PITCH_BEND = 3'h5
  } msg_kind_e;
  // Status nibbles
  localparam logic [3:0] STAT_NOTE_ON = 4'h9;
  localparam logic [3:0] STAT_NOTE_OFF = 4'h8;
  localparam logic [3:0] STAT_CONTROL = 4'hB;
  localparam logic [3:0] STAT_PROGRAM = 4'hC;
  localparam logic [3:0] STAT_PITCH = 4'hE;
  // Paired controller offset and value scaling
  localparam logic [6:0] PAIR_OFFSET = 7'h20;
  localparam int VAL_W = 16;
  localparam logic [VAL_W-1:0] VAL_FULL = 16'hFFFF;
  localparam logic [13:0] MAX14 = 14'h3FFF;
  localparam logic [6:0] MAX7 = 7'h7F;
  localparam int MAX_BYTES = 6;
endpackage

// ---- design/music_message_send.sv ----
// Music message framer with two-entry output buffer
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module music_message_send
  import music_msg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_kind,
  input wire logic [4:0] req_channel,
  input wire logic [6:0] req_number,
  input wire logic [VAL_W-1:0] req_value,
  input wire logic show_running,
  input wire logic music_mode,
  output logic req_dropped,
  output logic [7:0] out_byte,
  output logic out_valid,
  input wire logic out_ready
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } state_e;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_ok_n;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_ok_n = rst_sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Value scaling: round(v * max / 65535), computed as (v*max + 32767) / 65535
  function automatic logic [13:0] scale(input logic [VAL_W-1:0] v, input logic [13:0] mx);
    logic [31:0] prod;
    prod = 32'(v) * 32'(mx) + 32'(VAL_FULL >> 1);
    return 14'(prod / 32'(VAL_FULL));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Framer state
  state_e state_reg, state_next;
  logic [7:0] msg_reg [MAX_BYTES];
  logic [7:0] msg_next [MAX_BYTES];
  logic [2:0] len_reg, len_next;
  logic [2:0] idx_reg, idx_next;
  logic req_ready_reg, req_ready_next;
  logic dropped_reg, dropped_next;
  logic push;
  logic buf_ready;
  logic [3:0] chan;
  logic [6:0] v7;
  logic [13:0] v14;
  logic [7:0] ctrl_stat;
  logic accept;

  assign chan = 4'(req_channel - 5'h01);
  assign v7 = 7'(scale(req_value, 14'(MAX7)));
  assign v14 = scale(req_value, MAX14);
  assign ctrl_stat = {STAT_CONTROL, chan};
  assign accept = req_valid && req_ready_reg;
  assign push = (state_reg == ST_SEND) && buf_ready;

  // Next framer values
  always_comb begin
    state_next = state_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    dropped_next = 1'b0;
    for (int i = 0; i < MAX_BYTES; i++) begin
      msg_next[i] = msg_reg[i];
    end
    if (accept) begin
      if (!show_running || !music_mode || req_kind > 3'(KIND_PITCH_BEND)) begin
        dropped_next = 1'b1;
      end else begin
        state_next = ST_SEND;
        idx_next = 3'h0;
        unique case (msg_kind_e'(req_kind))
          KIND_NOTE_ON, KIND_NOTE_OFF: begin
            msg_next[0] = {(req_kind == 3'(KIND_NOTE_ON)) ? STAT_NOTE_ON : STAT_NOTE_OFF, chan};
            msg_next[1] = {1'b0, req_number};
            msg_next[2] = {1'b0, v7};
            len_next = 3'h3;
          end
          KIND_CONTROL: begin
            msg_next[0] = ctrl_stat;
            msg_next[1] = {1'b0, req_number};
            msg_next[2] = {1'b0, v7};
            len_next = 3'h3;
          end
          KIND_PAIRED_CONTROL: begin
            msg_next[0] = ctrl_stat;
            msg_next[1] = {3'b000, req_number[4:0]};
            msg_next[2] = {1'b0, v14[13:7]};
            msg_next[3] = ctrl_stat;
            msg_next[4] = {1'b0, 7'({2'b00, req_number[4:0]}) + PAIR_OFFSET};
            msg_next[5] = {1'b0, v14[6:0]};
            len_next = 3'h6;
          end
          KIND_PROGRAM: begin
            msg_next[0] = {STAT_PROGRAM, chan};
            msg_next[1] = {1'b0, req_number};
            len_next = 3'h2;
          end
          KIND_PITCH_BEND: begin
            msg_next[0] = {STAT_PITCH, chan};
            msg_next[1] = {1'b0, v14[6:0]};
            msg_next[2] = {1'b0, v14[13:7]};
            len_next = 3'h3;
          end
          default: begin
            len_next = 3'h0;
          end
        endcase
      end
    end else if (push) begin
      idx_next = idx_reg + 3'h1;
      if (idx_reg + 3'h1 == len_reg) begin
        state_next = ST_IDLE;
      end
    end
    req_ready_next = (state_next == ST_IDLE) && !accept;
  end

  // Framer registers
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_reg <= ST_IDLE;
      len_reg <= 3'h0;
      idx_reg <= 3'h0;
      req_ready_reg <= 1'b0;
      dropped_reg <= 1'b0;
      for (int i = 0; i < MAX_BYTES; i++) begin
        msg_reg[i] <= 8'h00;
      end
    end else begin
      state_reg <= state_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      req_ready_reg <= req_ready_next;
      dropped_reg <= dropped_next;
      for (int i = 0; i < MAX_BYTES; i++) begin
        msg_reg[i] <= msg_next[i];
      end
    end
  end
  assign req_ready = req_ready_reg;
  assign req_dropped = dropped_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; head entry drives the outputs
  logic [7:0] buf_reg [2];
  logic [7:0] buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic pop;
  logic out_valid_reg, out_valid_next;

  assign buf_ready = cnt_reg != 2'h2;
  assign pop = (cnt_reg != 2'h0) && out_ready;

  // Next buffer values
  always_comb begin
    buf_next[0] = buf_reg[0];
    buf_next[1] = buf_reg[1];
    cnt_next = cnt_reg;
    if (pop) begin
      buf_next[0] = buf_reg[1];
    end
    if (push) begin
      buf_next[2'(cnt_reg - (pop ? 2'h1 : 2'h0)) == 2'h0 ? 0 : 1] = msg_reg[idx_reg];
    end
    cnt_next = 2'(cnt_reg + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0));
    out_valid_next = cnt_next != 2'h0;
  end

  // Buffer registers
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      buf_reg[0] <= 8'h00;
      buf_reg[1] <= 8'h00;
      cnt_reg <= 2'h0;
      out_valid_reg <= 1'b0;
    end else begin
      buf_reg[0] <= buf_next[0];
      buf_reg[1] <= buf_next[1];
      cnt_reg <= cnt_next;
      out_valid_reg <= out_valid_next;
    end
  end
  assign out_byte = buf_reg[0];
  assign out_valid = out_valid_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_accept_bad;
    req_valid && req_ready && (!show_running || !music_mode);
  endsequence

  property p_drop_gate;
    @(posedge clk) disable iff (!rst_ok_n)
      s_accept_bad |=> req_dropped && state_reg == ST_IDLE;
  endproperty
  a_drop_gate: assert property (p_drop_gate) else $error("Request not discarded");

  property p_mode_gate;
    @(posedge clk) disable iff (!rst_ok_n)
      (state_reg == ST_IDLE && !music_mode) |=> state_reg == ST_IDLE;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("Sent outside music mode");

  property p_status_bit;
    @(posedge clk) disable iff (!rst_ok_n)
      push |-> msg_reg[idx_reg][7] == (idx_reg == 3'h0 || (len_reg == 3'h6 && idx_reg == 3'h3));
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("Bad bit 7");

  property p_note_on;
    @(posedge clk) disable iff (!rst_ok_n)
      (accept && show_running && music_mode && req_kind == 3'(KIND_NOTE_ON))
        |=> msg_reg[0] == {STAT_NOTE_ON, $past(chan)} && len_reg == 3'h3;
  endproperty
  a_note_on: assert property (p_note_on) else $error("Note on framing wrong");

  property p_pair;
    @(posedge clk) disable iff (!rst_ok_n)
      (state_reg == ST_SEND && len_reg == 3'h6) |-> msg_reg[4][6:0] == msg_reg[1][6:0] + PAIR_OFFSET;
  endproperty
  a_pair: assert property (p_pair) else $error("Paired controller offset wrong");

  property p_bend_order;
    @(posedge clk) disable iff (!rst_ok_n)
      (accept && show_running && music_mode && req_kind == 3'(KIND_PITCH_BEND))
        |=> msg_reg[1][6:0] == $past(v14[6:0]) && msg_reg[2][6:0] == $past(v14[13:7]);
  endproperty
  a_bend_order: assert property (p_bend_order) else $error("Bend byte order wrong");

  property p_program;
    @(posedge clk) disable iff (!rst_ok_n)
      (accept && show_running && music_mode && req_kind == 3'(KIND_PROGRAM))
        |=> msg_reg[0][7:4] == STAT_PROGRAM && len_reg == 3'h2;
  endproperty
  a_program: assert property (p_program) else $error("Program framing wrong");

  property p_full_scale;
    @(posedge clk) disable iff (!rst_ok_n)
      (req_value == VAL_FULL) |-> v7 == MAX7 && v14 == MAX14;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("Full scale not reached");

  property p_contiguous;
    @(posedge clk) disable iff (!rst_ok_n)
      (state_reg == ST_SEND) |-> !req_ready;
  endproperty
  a_contiguous: assert property (p_contiguous) else $error("Request taken mid message");

  property p_out_hold;
    @(posedge clk) disable iff (!rst_ok_n)
      (out_valid && !out_ready) |=> out_valid && $stable(out_byte);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("Byte lost while stalled");

endmodule

// ---- bench/music_receiver_model.sv ----
// Receiving instrument model that collects bytes and can stall
`timescale 1ns/10ps
module music_receiver_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  output logic out_ready
);
  logic [7:0] got[$];
  logic off_seen;
  logic [1:0] phase;
  //////////////////////////////////////////////////////////////////////////////
  // Take bytes; in slow mode accept one cycle out of four
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      phase <= 2'h0;
      off_seen <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      out_ready <= !slow || (phase == 2'h3);
      if (out_valid && out_ready) begin
        // Note-on with zero velocity taken as a note-off
        if (got.size() >= 2 && got[got.size()-2][7:4] == 4'h9 && out_byte == 8'h00) begin
          off_seen <= 1'b1;
        end
        got.push_back(out_byte);
      end
    end
  end
endmodule

// ---- bench/music_message_send_tb_top.sv ----
// Self-checking bench for the music message framer
`timescale 1ns/10ps
module music_message_send_tb_top;
  import music_msg_pkg::*;
  logic clk, rst_n, req_valid, show_running, music_mode, slow, req_ready, req_dropped, out_valid, out_ready;
  logic [2:0] req_kind;
  logic [4:0] req_channel;
  logic [6:0] req_number;
  logic [VAL_W-1:0] req_value;
  logic [7:0] out_byte;
  int bad_count, check_count, drops, cycles;
  music_message_send u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_channel(req_channel), .req_number(req_number), .req_value(req_value),
    .show_running(show_running), .music_mode(music_mode), .req_dropped(req_dropped),
    .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready));
  music_receiver_model u_rx (.clk(clk), .rst_n(rst_n), .slow(slow), .out_byte(out_byte),
    .out_valid(out_valid), .out_ready(out_ready));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, drop pulse counter and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (req_dropped === 1'b1) drops++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int scale(input logic [15:0] v, input int mx);
    return (int'(v) * mx + 32767) / 65535;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // One request, then compare every byte and the drop count
  task automatic xfer(input logic [2:0] k, input logic [4:0] ch, input logic [6:0] n, input logic [15:0] v,
    input bit drop);
    logic [7:0] e[$];
    logic [3:0] c;
    logic [6:0] s;
    logic [13:0] w;
    int d0, i;
    logic rdy;
    c = 4'(ch - 5'h01);
    s = 7'(scale(v, 127));
    w = 14'(scale(v, 16383));
    case (k)
      KIND_NOTE_ON: e = '{{STAT_NOTE_ON, c}, {1'b0, n}, {1'b0, s}};
      KIND_NOTE_OFF: e = '{{STAT_NOTE_OFF, c}, {1'b0, n}, {1'b0, s}};
      KIND_CONTROL: e = '{{STAT_CONTROL, c}, {1'b0, n}, {1'b0, s}};
      KIND_PAIRED_CONTROL: e = '{{STAT_CONTROL, c}, {3'h0, n[4:0]}, {1'b0, w[13:7]},
        {STAT_CONTROL, c}, {3'h1, n[4:0]}, {1'b0, w[6:0]}};
      KIND_PROGRAM: e = '{{STAT_PROGRAM, c}, {1'b0, n}};
      default: e = '{{STAT_PITCH, c}, {1'b0, w[6:0]}, {1'b0, w[13:7]}};
    endcase
    if (drop) e.delete();
    d0 = drops;
    u_rx.got.delete();
    req_kind <= k;
    req_channel <= ch;
    req_number <= n;
    req_value <= v;
    req_valid <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      rdy = req_ready;
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 50);
    req_valid <= 1'b0;
    check(rdy, 1'b1);
    repeat (4) @(posedge clk);
    i = 0;
    while ((u_rx.got.size() < e.size() || req_ready !== 1'b1) && i < 300) begin
      @(posedge clk);
      i++;
    end
    check(i < 300, 1'b1);
    repeat (4) @(posedge clk);
    check(u_rx.got.size(), e.size());
    foreach (e[j]) check(u_rx.got[j], e[j]);
    check(drops - d0, drop);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_notes();
    xfer(KIND_NOTE_ON, 5'h01, 7'h3C, 16'hFFFF, 0);
    xfer(KIND_NOTE_OFF, 5'h10, 7'h7F, 16'h0000, 0);
    xfer(KIND_NOTE_ON, 5'h03, 7'h40, 16'h0000, 0);
    check(u_rx.off_seen, 1'b1);
  endtask
  task automatic t_control();
    xfer(KIND_CONTROL, 5'h05, 7'h07, 16'h8000, 0);
    xfer(KIND_PAIRED_CONTROL, 5'h05, 7'h1F, 16'h8000, 0);
    xfer(KIND_PAIRED_CONTROL, 5'h02, 7'h00, 16'hFFFF, 0);
  endtask
  task automatic t_program();
    xfer(KIND_PROGRAM, 5'h0A, 7'h55, 16'h1234, 0);
  endtask
  task automatic t_stall();
    slow <= 1'b1;
    xfer(KIND_PITCH_BEND, 5'h01, 7'h00, 16'h8000, 0);
    xfer(KIND_PAIRED_CONTROL, 5'h10, 7'h11, 16'h4321, 0);
    slow <= 1'b0;
    xfer(KIND_PITCH_BEND, 5'h0F, 7'h00, 16'h0001, 0);
  endtask
  task automatic t_gates();
    show_running <= 1'b0;
    xfer(KIND_NOTE_ON, 5'h01, 7'h01, 16'hFFFF, 1);
    show_running <= 1'b1;
    music_mode <= 1'b0;
    xfer(KIND_CONTROL, 5'h01, 7'h01, 16'hFFFF, 1);
    music_mode <= 1'b1;
    xfer(3'h6, 5'h01, 7'h01, 16'hFFFF, 1);
    xfer(3'h7, 5'h01, 7'h01, 16'hFFFF, 1);
    xfer(KIND_PROGRAM, 5'h01, 7'h7F, 16'h0000, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_channel = 5'h01;
    req_number = 7'h00;
    req_value = 16'h0000;
    show_running = 1'b1;
    music_mode = 1'b1;
    slow = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_notes();
    t_control();
    t_program();
    t_stall();
    t_gates();
    end_of_test();
  end
endmodule
